// [verilog/pseq_pkg.sv]
`default_nettype none
package pseq_pkg;
	// Widths and depths
	localparam int PC_W = 13;
	localparam int BANK_W = 3;
	localparam int ADDR_W = 16;
	localparam int WORD_W = 16;
	localparam int STACK_DEPTH = 8;
	localparam int WAVE_SHIFT = 5;
	// Oscillator halving and four phases per instruction cycle
	localparam int OSC_DIV = 2;
	localparam int PHASE_COUNT = 4;
	// Register offsets on the data address space
	localparam logic [7:0] OFF_PC_LOW = 8'h06;
	localparam logic [7:0] OFF_BANK = 8'h1c;
	localparam logic [7:0] OFF_SEQ_STATUS = 8'h1e;
	// Counter, bank and instruction word load values
	localparam logic [12:0] VEC_RESET = 13'h0000;
	localparam logic [12:0] VEC_TMR0 = 13'h0008;
	localparam logic [12:0] VEC_TMR1 = 13'h000c;
	localparam logic [2:0] BANK_RESET = 3'h0;
	localparam logic [15:0] WORD_RESET = 16'h0000;
	// Counter load source chosen at the end of each instruction cycle
	typedef enum logic [2:0] {
		SRC_INC, SRC_SKIP, SRC_LOW, SRC_JUMP, SRC_RET, SRC_INT0, SRC_INT1
	} pseq_src_type;
	// Phases of one instruction cycle
	typedef enum logic [1:0] {PH1, PH2, PH3, PH4} pseq_phase_type;
endpackage
`default_nettype wire

// [verilog/pseq_stack.sv]
`timescale 1ns/1ns
`default_nettype none
module pseq_stack #(
	parameter int DEPTH = 8,
	parameter int WIDTH = 13
) (
	input wire logic ref_clk_in,
	input wire logic reset_n_in,
	input wire logic push_in,
	input wire logic pop_in,
	input wire logic [WIDTH-1:0] push_data_in,
	output logic [WIDTH-1:0] top_out,
	output logic full_out,
	output logic [$clog2(DEPTH):0] depth_out
);
	localparam int PW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [PW-1:0] wr_ptr;
	logic [PW:0] depth;
	wire [PW-1:0] top_ptr = wr_ptr - 1'b1;

	// Circular store: a push onto a full stack drops the oldest entry
	always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			wr_ptr <= '0;
			depth <= '0;
		end else if (push_in) begin
			wr_ptr <= wr_ptr + 1'b1;
			if (depth != (PW+1)'(DEPTH))
				depth <= depth + 1'b1;
		end else if (pop_in && depth != '0) begin
			wr_ptr <= top_ptr;
			depth <= depth - 1'b1;
		end
	end

	// Storage without reset, only read behind a valid depth
	always_ff @(posedge ref_clk_in) begin
		if (push_in)
			mem[wr_ptr] <= push_data_in;
	end

	assign top_out = mem[top_ptr];
	assign full_out = (depth == (PW+1)'(DEPTH));
	assign depth_out = depth;
endmodule
`default_nettype wire

// [verilog/pseq_rom_addr.sv]
`timescale 1ns/1ns
`default_nettype none
module pseq_rom_addr
	import pseq_pkg::*;
(
	input wire logic ref_clk_in,
	input wire logic reset_n_in,
	input wire logic wave_sel_in,
	input wire logic [pseq_pkg::BANK_W-1:0] bank_in,
	input wire logic [pseq_pkg::PC_W-1:0] pc_in,
	input wire logic [15:0] sample_start_address_in,
	output logic [pseq_pkg::ADDR_W-1:0] rom_address_bus_out
);
	// Bank sits above the counter; samples sit on 32-word boundaries
	wire [ADDR_W-1:0] prog_addr = {bank_in, pc_in};
	wire [ADDR_W-1:0] wave_addr =
		ADDR_W'({sample_start_address_in, {WAVE_SHIFT{1'b0}}});
	wire [ADDR_W-1:0] next_addr = wave_sel_in ? wave_addr : prog_addr;

	// Registered so the pins never glitch between sources
	always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
		if (!reset_n_in)
			rom_address_bus_out <= '0;
		else
			rom_address_bus_out <= next_addr;
	end
endmodule
`default_nettype wire

// [verilog/pseq_sequencer.sv]
// Chosen here: the address-and-strobe port.
`timescale 1ns/1ns
`default_nettype none
// What this block does
// - Halve oscillator; four phases per cycle.
// - Fetch next while current executes.
// - Counter changes cost a dummy cycle.
// - Program counter is thirteen bits wide.
// - Counter advances after every fetch.
// - Jump loads code bits; return loads stack.
// - True skip discards prefetch, reaches PC+2.
// - Low byte write keeps upper five bits.
// - Drive sixteen-bit address to external ROM.
// - Program address is bank above counter.
// - Wave address is start shifted five.
// - Banks hold 8192 sixteen-bit words.
// - Reset clears counter, selects bank zero.
// - First timer vectors to word 008H.
// - Second timer vectors to word 00CH.
// - New bank applies after next instruction.
// - Calls and interrupts push eight-level stack.
// - Full stack holds interrupt, keeps request.
module pseq_sequencer (
	input wire logic ref_clk_in,
	input wire logic reset_n_in,
	input wire logic [7:0] reg_addr_in,
	input wire logic [7:0] reg_wdata_in,
	input wire logic reg_wr_in,
	input wire logic reg_rd_in,
	output logic [7:0] reg_rdata_out,
	input wire logic [pseq_pkg::WORD_W-1:0] rom_data_in,
	output logic [pseq_pkg::ADDR_W-1:0] rom_address_bus_out,
	input wire logic wave_req_in,
	input wire logic [15:0] sample_start_address_in,
	output logic wave_slot_out,
	input wire logic jump_in,
	input wire logic call_in,
	input wire logic ret_in,
	input wire logic skip_in,
	input wire logic [pseq_pkg::PC_W-1:0] target_in,
	input wire logic tmr0_ovf_in,
	input wire logic tmr1_ovf_in,
	input wire logic tmr0_int_en_in,
	input wire logic tmr1_int_en_in,
	output logic sys_clk_out,
	output logic [1:0] phase_out,
	output logic cycle_end_out,
	output logic [pseq_pkg::WORD_W-1:0] instr_out,
	output logic instr_valid_out,
	output logic int_ack_out
);
	import pseq_pkg::*;

	logic [$clog2(OSC_DIV)-1:0] div_cnt;
	pseq_phase_type phase;
	logic [PC_W-1:0] pc;
	logic [BANK_W-1:0] bank_sel;
	logic [BANK_W-1:0] bank_act;
	logic bank_stage0;
	logic bank_stage1;
	logic low_pend;
	logic [7:0] low_data;
	logic [WORD_W-1:0] fetch_word;
	logic pend0;
	logic pend1;
	logic [PC_W-1:0] stack_top;
	logic stack_full;
	logic [$clog2(STACK_DEPTH):0] stack_depth;
	pseq_src_type src;
	logic [PC_W-1:0] next_pc;
	logic [7:0] next_rdata;

	////////////////////////////////////////////////////////////////////////
	// Timing: sys tick every second oscillator edge, four phases per cycle

	wire sys_tick = (div_cnt == ($clog2(OSC_DIV))'(OSC_DIV - 1));
	wire cycle_end = sys_tick && (phase == PH4);
	wire fetch_latch = sys_tick && (phase == PH2);

	// Divider and phase counter
	always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			div_cnt <= '0;
			phase <= PH1;
		end else begin
			div_cnt <= div_cnt + 1'b1;
			if (sys_tick) begin
				unique case (phase)
					PH1: phase <= PH2;
					PH2: phase <= PH3;
					PH3: phase <= PH4;
					PH4: phase <= PH1;
				endcase
			end
		end
	end

	// Square wave at half the oscillator rate
	always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
		if (!reset_n_in)
			sys_clk_out <= 1'b0;
		else
			sys_clk_out <= !sys_tick;
	end

	assign phase_out = phase;
	assign cycle_end_out = cycle_end;

	////////////////////////////////////////////////////////////////////////
	// Register port

	wire wr_low = reg_wr_in && (reg_addr_in == OFF_PC_LOW);
	wire wr_bank = reg_wr_in && (reg_addr_in == OFF_BANK);

	// Read mux; unmapped offsets read as zero
	always_comb begin
		next_rdata = 8'h00;
		if (reg_addr_in == OFF_PC_LOW)
			next_rdata = pc[7:0];
		else if (reg_addr_in == OFF_BANK)
			next_rdata = {5'h00, bank_sel};
		else if (reg_addr_in == OFF_SEQ_STATUS)
			next_rdata = {pend1, pend0, stack_full, 1'b0,
				4'(stack_depth)};
	end

	// Read data stand only in the cycle after the strobe
	always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
		if (!reset_n_in)
			reg_rdata_out <= 8'h00;
		else
			reg_rdata_out <= reg_rd_in ? next_rdata : 8'h00;
	end

	// Low byte write is a short jump taken at the end of the cycle
	always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			low_pend <= 1'b0;
			low_data <= 8'h00;
		end else if (wr_low) begin
			low_pend <= 1'b1;
			low_data <= reg_wdata_in;
		end else if (cycle_end) begin
			low_pend <= 1'b0;
		end
	end

	// Bank change waits for the following instruction to finish;
	// a rewrite still waiting holds the change back one more cycle
	always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			bank_sel <= BANK_RESET;
			bank_act <= BANK_RESET;
			bank_stage0 <= 1'b0;
			bank_stage1 <= 1'b0;
		end else begin
			if (wr_bank)
				bank_sel <= reg_wdata_in[BANK_W-1:0];
			if (cycle_end) begin
				bank_stage1 <= bank_stage0 && !wr_bank;
				if (bank_stage1 && !bank_stage0)
					bank_act <= bank_sel;
			end
			if (wr_bank)
				bank_stage0 <= 1'b1;
			else if (cycle_end)
				bank_stage0 <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Interrupt requests and counter source selection

	wire take0 = pend0 && tmr0_int_en_in && !stack_full;
	wire take1 = pend1 && tmr1_int_en_in && !stack_full;
	wire exec_ret = instr_valid_out && ret_in;
	wire exec_jump = instr_valid_out && (jump_in || call_in);
	wire exec_skip = instr_valid_out && skip_in;

	// Executing instruction outranks interrupts; dummies take none
	always_comb begin
		src = SRC_INC;
		if (exec_ret)
			src = SRC_RET;
		else if (exec_jump)
			src = SRC_JUMP;
		else if (low_pend)
			src = SRC_LOW;
		else if (exec_skip)
			src = SRC_SKIP;
		else if (instr_valid_out && take0)
			src = SRC_INT0;
		else if (instr_valid_out && take1)
			src = SRC_INT1;
	end

	wire ack = cycle_end && (src == SRC_INT0 || src == SRC_INT1);
	wire push = ack || (cycle_end && src == SRC_JUMP && call_in);
	wire pop = cycle_end && src == SRC_RET;
	assign int_ack_out = ack;

	// Request flags: a new overflow wins over its own acknowledge
	always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			pend0 <= 1'b0;
			pend1 <= 1'b0;
		end else begin
			pend0 <= tmr0_ovf_in
				|| (pend0 && !(ack && src == SRC_INT0));
			pend1 <= tmr1_ovf_in
				|| (pend1 && !(ack && src == SRC_INT1));
		end
	end

	// Next counter value; plain truncation wraps inside the bank
	always_comb begin
		next_pc = PC_W'(pc + 1'b1);
		unique case (src)
			SRC_INC: next_pc = PC_W'(pc + 1'b1);
			SRC_SKIP: next_pc = PC_W'(pc + 1'b1);
			SRC_LOW: next_pc = {pc[PC_W-1:8], low_data};
			SRC_JUMP: next_pc = target_in;
			SRC_RET: next_pc = stack_top;
			SRC_INT0: next_pc = VEC_TMR0;
			SRC_INT1: next_pc = VEC_TMR1;
			default: next_pc = PC_W'(pc + 1'b1);
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	// Fetch and execute pipeline

	// Fetched word caught mid-cycle, handed to execute at cycle end
	always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			pc <= VEC_RESET;
			fetch_word <= WORD_RESET;
			instr_out <= WORD_RESET;
			instr_valid_out <= 1'b0;
		end else begin
			if (fetch_latch)
				fetch_word <= rom_data_in;
			if (cycle_end) begin
				pc <= next_pc;
				instr_out <= fetch_word;
				instr_valid_out <= (src == SRC_INC);
			end
		end
	end

	// The interrupted or called-over fetch address is the return point
	pseq_stack #(
		.DEPTH(STACK_DEPTH),
		.WIDTH(PC_W)
	) u_stack (
		.ref_clk_in(ref_clk_in),
		.reset_n_in(reset_n_in),
		.push_in(push),
		.pop_in(pop),
		.push_data_in(pc),
		.top_out(stack_top),
		.full_out(stack_full),
		.depth_out(stack_depth)
	);

	////////////////////////////////////////////////////////////////////////
	// ROM address: program in the first half, wavetable in the second

	wire wave_sel = wave_req_in && (phase == PH3 || phase == PH4);

	// Slot flag lines up with the registered address
	always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
		if (!reset_n_in)
			wave_slot_out <= 1'b0;
		else
			wave_slot_out <= wave_sel;
	end

	pseq_rom_addr u_rom_addr (
		.ref_clk_in(ref_clk_in),
		.reset_n_in(reset_n_in),
		.wave_sel_in(wave_sel),
		.bank_in(bank_act),
		.pc_in(pc),
		.sample_start_address_in(sample_start_address_in),
		.rom_address_bus_out(rom_address_bus_out)
	);

	////////////////////////////////////////////////////////////////////////
	// Checks

	default clocking cb @(posedge ref_clk_in);
	endclocking
	default disable iff (!reset_n_in);

	chk_cycle_length: assert property (
		cycle_end |=> !cycle_end [*7] ##1 cycle_end)
		else $error("instruction cycle is not eight oscillator edges");
	chk_pc_increment: assert property (
		cycle_end && src == SRC_INC |=> pc == PC_W'($past(pc) + 1'b1))
		else $error("counter did not advance by one");
	chk_dummy_cycle: assert property (
		cycle_end && src != SRC_INC |=> !instr_valid_out [*8])
		else $error("no dummy cycle after counter change");
	chk_jump_load: assert property (
		cycle_end && src == SRC_JUMP |=> pc == $past(target_in))
		else $error("jump target not loaded");
	chk_skip_step: assert property (
		cycle_end && src == SRC_SKIP
		|=> pc == PC_W'($past(pc) + 1'b1) && !instr_valid_out)
		else $error("skip did not discard prefetch");
	chk_low_upper: assert property (
		cycle_end && src == SRC_LOW
		|=> pc[12:8] == $past(pc[12:8]) && pc[7:0] == $past(low_data))
		else $error("low byte write disturbed upper bits");
	chk_prog_address: assert property (
		!wave_sel |=> rom_address_bus_out == {$past(bank_act), $past(pc)})
		else $error("program address wrong");
	chk_wave_address: assert property (
		wave_sel |=> rom_address_bus_out
			== {$past(sample_start_address_in[10:0]), 5'h00})
		else $error("wavetable address wrong");
	chk_tmr_vector: assert property (
		cycle_end && src == SRC_INT0 |=> pc == VEC_TMR0 && !instr_valid_out)
		else $error("first timer vector wrong");
	chk_full_hold: assert property (
		stack_full && !pop |=> !int_ack_out)
		else $error("interrupt taken with stack full");
	chk_bank_delay: assert property (
		wr_bank && !cycle_end |=> bank_act == $past(bank_act) [*8])
		else $error("bank applied too early");
	chk_ret_load: assert property (
		cycle_end && src == SRC_RET |=> pc == $past(stack_top))
		else $error("return address not loaded");
	chk_tmr1_vector: assert property (
		cycle_end && src == SRC_INT1 |=> pc == VEC_TMR1 && !instr_valid_out)
		else $error("second timer vector wrong");
	chk_push_return: assert property (
		push |=> stack_top == $past(pc))
		else $error("return point not pushed");

	cov_jump: cover property (cycle_end && src == SRC_JUMP);
	cov_int_ack: cover property (int_ack_out);
	cov_skip: cover property (cycle_end && src == SRC_SKIP);
	cov_full_wait: cover property (stack_full && pend0 && tmr0_int_en_in);
	cov_low_write: cover property (cycle_end && src == SRC_LOW);
endmodule
`default_nettype wire

// [testbench/pseq_rom_model.sv]
`timescale 1ns/1ns
`default_nettype none
module pseq_rom_model (
	input wire logic [15:0] addr_in,
	output logic [15:0] data_out
);
	// Each word mixes its own address, so a wrong address reads wrong
	assign data_out = addr_in ^ 16'ha5a5;
endmodule
`default_nettype wire

// [testbench/testbench.sv]
`timescale 1ns/1ns
`default_nettype none
module testbench;
	import pseq_pkg::*;
	logic ref_clk_in = 0, reset_n_in = 0, reg_wr_in = 0, reg_rd_in = 0;
	logic [7:0] reg_addr_in = 0, reg_wdata_in = 0, reg_rdata_out;
	logic [15:0] rom_data_in, rom_address_bus_out, instr_out;
	logic [15:0] sample_start_address_in = 0;
	logic wave_req_in = 0, jump_in = 0, call_in = 0, ret_in = 0, skip_in = 0;
	logic [12:0] target_in = 0;
	logic tmr0_ovf_in = 0, tmr1_ovf_in = 0;
	logic tmr0_int_en_in = 0, tmr1_int_en_in = 0;
	logic wave_slot_out, sys_clk_out, cycle_end_out, instr_valid_out;
	logic int_ack_out;
	logic [1:0] phase_out;
	int err_total = 0, n_tests = 0, cyc = 0;
	logic [12:0] nx = 0;
	logic [2:0] b = 0;
	logic [15:0] iw;
	logic iv, ia;
	////////////////////////////////////////////////////////////////////////
	// Clock, design and ROM
	always #20 ref_clk_in = ~ref_clk_in;
	pseq_sequencer DUT (.ref_clk_in, .reset_n_in, .reg_addr_in,
		.reg_wdata_in, .reg_wr_in, .reg_rd_in, .reg_rdata_out, .rom_data_in,
		.rom_address_bus_out, .wave_req_in, .sample_start_address_in,
		.wave_slot_out, .jump_in, .call_in, .ret_in, .skip_in, .target_in,
		.tmr0_ovf_in, .tmr1_ovf_in, .tmr0_int_en_in, .tmr1_int_en_in,
		.sys_clk_out, .phase_out, .cycle_end_out, .instr_out,
		.instr_valid_out, .int_ack_out);
	pseq_rom_model rom (.addr_in(rom_address_bus_out), .data_out(rom_data_in));
	// Hang guard, well above the expected few hundred cycles
	always @(posedge ref_clk_in) begin
		cyc <= cyc + 1;
		if (cyc == 4000) begin
			err_total++;
			stop_test();
		end
	end
	////////////////////////////////////////////////////////////////////////
	// Helpers
	function automatic logic [15:0] w(input logic [15:0] a);
		return a ^ 16'ha5a5;
	endfunction
	task automatic chk(input string nm, input logic [15:0] e, g);
		n_tests++;
		if (g !== e) begin
			$display("[ERR] %s expected %h seen %h", nm, e, g);
			err_total++;
		end
	endtask
	task automatic wr(input logic [7:0] a, d);
		reg_addr_in <= a;
		reg_wdata_in <= d;
		reg_wr_in <= 1'b1;
		@(posedge ref_clk_in);
		reg_wr_in <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, e);
		reg_addr_in <= a;
		reg_rd_in <= 1'b1;
		@(posedge ref_clk_in);
		reg_rd_in <= 1'b0;
		@(negedge ref_clk_in);
		chk("rdata", {8'h0, e}, {8'h0, reg_rdata_out});
		@(posedge ref_clk_in);
	endtask
	// Controls held up to the closing edge, so the decoder view is stable
	task automatic step(input logic [3:0] c, input logic [12:0] t);
		{jump_in, call_in, ret_in, skip_in} <= c;
		target_in <= t;
		do @(negedge ref_clk_in); while (cycle_end_out !== 1'b1);
		ia = int_ack_out;
		@(posedge ref_clk_in);
		{jump_in, call_in, ret_in, skip_in} <= 4'h0;
		@(negedge ref_clk_in);
		iw = instr_out;
		iv = instr_valid_out;
		@(posedge ref_clk_in);
	endtask
	task automatic run;
		step(4'h0, 13'h0);
		chk("valid", 16'h1, {15'h0, iv});
		chk("instr", w({b, nx}), iw);
		nx = nx + 13'h1;
	endtask
	task automatic dummy(input logic [3:0] c, input logic [12:0] t);
		step(c, t);
		chk("valid", 16'h0, {15'h0, iv});
	endtask
	////////////////////////////////////////////////////////////////////////
	// Scenarios
	task automatic t_phase;
		logic sc;
		do @(negedge ref_clk_in); while (cycle_end_out !== 1'b1);
		@(posedge ref_clk_in);
		for (int i = 0; i < 8; i++) begin
			@(negedge ref_clk_in);
			chk("phase", 16'(i / 2), {14'h0, phase_out});
			chk("cycle_end", 16'(i == 7), {15'h0, cycle_end_out});
			if (i > 0) chk("sys_clk", {15'h0, ~sc}, {15'h0, sys_clk_out});
			sc = sys_clk_out;
		end
		@(posedge ref_clk_in);
		@(negedge ref_clk_in);
		chk("instr", w(16'h0001), instr_out);
		nx = 13'h0002;
		@(posedge ref_clk_in);
	endtask
	task automatic t_seq;
		run();
		rd(OFF_PC_LOW, nx[7:0]);
		wr(8'h30, 8'hff);
		rd(8'h30, 8'h00);
	endtask
	// Jump near the top, then a low byte write, then wrap past the end
	task automatic t_jump;
		dummy(4'h8, 13'h1ffe);
		nx = 13'h1ffe;
		run();
		wr(OFF_PC_LOW, 8'hfe);
		dummy(4'h0, 13'h0);
		nx = 13'h1ffe;
		run();
		run();
		run();
		run();
	endtask
	task automatic t_skip;
		dummy(4'h1, 13'h0);
		nx = nx + 13'h1;
		run();
	endtask
	task automatic t_bank;
		wr(OFF_BANK, 8'h05);
		rd(OFF_BANK, 8'h05);
		run();
		run();
		b = 3'h5;
		run();
	endtask
	task automatic t_wave;
		wave_req_in <= 1'b1;
		sample_start_address_in <= 16'h0123;
		repeat (8) begin
			@(negedge ref_clk_in);
			if (wave_slot_out === 1'b1) break;
		end
		chk("wave_slot", 16'h1, {15'h0, wave_slot_out});
		chk("wave_addr", 16'h2460, rom_address_bus_out);
		@(posedge ref_clk_in);
		run();
		wave_req_in <= 1'b0;
	endtask
	task automatic t_mask;
		tmr1_ovf_in <= 1'b1;
		@(posedge ref_clk_in);
		tmr1_ovf_in <= 1'b0;
		run();
		chk("int_ack", 16'h0, {15'h0, ia});
		// Masked request stays recorded until its enable comes
		rd(OFF_SEQ_STATUS, 8'h80);
	endtask
	task automatic t_int(input logic sel, input logic [12:0] v);
		logic [12:0] ra;
		{tmr1_ovf_in, tmr0_ovf_in} <= {sel, ~sel};
		@(posedge ref_clk_in);
		{tmr1_ovf_in, tmr0_ovf_in} <= 2'b00;
		ra = nx;
		dummy(4'h0, 13'h0);
		chk("int_ack", 16'h1, {15'h0, ia});
		nx = v;
		// Second-timer request from the masked test waits on the first pass
		rd(OFF_SEQ_STATUS, {~sel, 7'h01});
		run();
		dummy(4'h2, 13'h0);
		nx = ra;
		run();
	endtask
	// Fill the stack, then an overflow must wait for a return
	task automatic t_full;
		logic [12:0] ra;
		for (int i = 0; i < 8; i++) begin
			ra = nx;
			nx = 13'h0100 + 13'(i * 16);
			dummy(4'h4, nx);
			run();
		end
		rd(OFF_SEQ_STATUS, 8'h28);
		tmr0_ovf_in <= 1'b1;
		@(posedge ref_clk_in);
		tmr0_ovf_in <= 1'b0;
		run();
		chk("int_ack", 16'h0, {15'h0, ia});
		rd(OFF_SEQ_STATUS, 8'h68);
		dummy(4'h2, 13'h0);
		nx = ra;
		run();
		dummy(4'h0, 13'h0);
		chk("int_ack", 16'h1, {15'h0, ia});
		nx = VEC_TMR0;
		run();
	endtask
	task automatic stop_test;
		$display("checks %0d mismatches %0d", n_tests, err_total);
		if (err_total == 0 && n_tests > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		repeat (20) @(posedge ref_clk_in);
		reset_n_in <= 1'b1;
		t_phase();
		t_seq();
		t_jump();
		t_skip();
		t_bank();
		t_wave();
		t_mask();
		tmr0_int_en_in <= 1'b1;
		t_int(1'b0, VEC_TMR0);
		tmr1_int_en_in <= 1'b1;
		t_int(1'b1, VEC_TMR1);
		t_full();
		stop_test();
	end
endmodule
`default_nettype wire
